/* design/iocfg_regs.sv */
// IO configuration register bank of the reader front end with AHB-Lite access
//
// Overview of operation
// - Bit 7 of the first register set selects single driver antenna drive, clear selects both.
// - In single drive the select bit picks driver and input one when 0, two when 1.
// - The receive water level is 64 bytes when its select bit is 0 and 80 bytes when 1.
// - The transmit water level is 32 bytes when its select bit is 0 and 16 bytes when 1.
// - The crystal select bit picks 13.56 MHz when 0 and 27.12 MHz when 1, and powers up as 1.
// - With the crystal running, host clock codes 00, 01, 10 give 3.39, 6.78 and 13.56 MHz.
// - Host clock code 11 disables the host clock output and holds it low.
// - Crystal stopped and output enabled gives a 32 kHz clock unless the suppress bit is set.
// - Bit 4 of the second register pulls the data-out line down while selected and not driven.
// - Bit 3 of the second register pulls the data-out line down while deselected.
// - Bit 2 of the second register selects the stronger data-out drive for a 1.8 V supply.
// - The slow ramp bit makes the transmitter take at least 10 us from 10% to 90% at turn-on.
// - The supply mode bit selects 5 V operation when 0 and 3.3 V operation when 1.
// - Bit 6 of the second register disables the digital supply regulator.
// - Both registers take their defaults at power-up only and at no other event.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module iocfg_regs #(
  parameter int LF_HALF = iocfg_pkg::LF_HALF_CYC,
  parameter int STEP_CYC = iocfg_pkg::RAMP_STEP_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic OSC_RUNNING,
  input wire logic XTAL_DIV_CLK,
  input wire logic SS_N,
  input wire logic MISO_OE,
  input wire logic TX_ON,
  output logic SINGLE_DRIVE,
  output logic ANT_DRV_ONE_EN,
  output logic ANT_DRV_TWO_EN,
  output logic ANT_IN_TWO_SEL,
  output logic [6:0] RX_WATER_LEVEL,
  output logic [6:0] TX_WATER_LEVEL,
  output logic XTAL_27M_SEL,
  output logic [1:0] HOST_CLK_DIV,
  output logic HOST_CLK,
  output logic MISO_PD_EN,
  output logic MISO_DRIVE_HI,
  output logic LOW_SUPPLY_MODE,
  output logic DIG_REG_OFF,
  output logic TX_RAMP_SLOW,
  output logic [3:0] TX_LEVEL
);

  // Counters are 10 bits wide; the limits below keep them there
  generate
    if (LF_HALF < 1 || LF_HALF > 1023 || STEP_CYC < 1 || STEP_CYC > 1023) begin : g_bad_par
      $error("iocfg_regs counts out of range");
    end
  endgenerate

  localparam logic [9:0] LF_LAST = 10'(LF_HALF - 1);
  localparam logic [9:0] STEP_LAST = 10'(STEP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic osc_run_s;
  logic xtal_clk_s;
  logic ss_n_s;

  iocfg_sync #(.STAGES(2), .RST_VAL(1'b0)) u_sync_osc (
    .clk(REF_CLK),
    .rst_n(NRST),
    .async_in(OSC_RUNNING),
    .sync_out(osc_run_s)
  );

  iocfg_sync #(.STAGES(2), .RST_VAL(1'b0)) u_sync_xclk (
    .clk(REF_CLK),
    .rst_n(NRST),
    .async_in(XTAL_DIV_CLK),
    .sync_out(xtal_clk_s)
  );

  iocfg_sync #(.STAGES(2), .RST_VAL(1'b1)) u_sync_ss (
    .clk(REF_CLK),
    .rst_n(NRST),
    .async_in(SS_N),
    .sync_out(ss_n_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave and register storage

  logic dph_wr_q;
  logic dph_wr_d;
  logic [1:0] dph_hit_q;
  logic [1:0] dph_hit_d;
  logic [7:0] cfg_one_q;
  logic [7:0] cfg_one_d;
  logic [7:0] cfg_two_q;
  logic [7:0] cfg_two_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic aph_go;
  logic [1:0] aph_hit;

  // Address phase decode; only whole-word transfers reach a register
  always_comb begin
    aph_go = HSEL & HTRANS[1] & HREADY;
    aph_hit[0] = (HADDR[31:2] == iocfg_pkg::IO_CONFIG_ONE_IDX) && (HSIZE == 3'h2);
    aph_hit[1] = (HADDR[31:2] == iocfg_pkg::IO_CONFIG_TWO_IDX) && (HSIZE == 3'h2);
  end

  // Write data lands in the data phase; read data is taken from the next
  // register values so a read right behind a write sees the new contents
  always_comb begin
    dph_wr_d = aph_go & HWRITE;
    dph_hit_d = aph_go ? aph_hit : 2'h0;
    cfg_one_d = cfg_one_q;
    cfg_two_d = cfg_two_q;
    if (dph_wr_q && dph_hit_q[0]) begin
      cfg_one_d = HWDATA[7:0] & iocfg_pkg::IO_CONFIG_ONE_MASK;
    end
    if (dph_wr_q && dph_hit_q[1]) begin
      cfg_two_d = HWDATA[7:0] & iocfg_pkg::IO_CONFIG_TWO_MASK;
    end
    rdata_d = 32'h00000000;
    if (aph_go && !HWRITE && aph_hit[0]) begin
      rdata_d = {24'h000000, cfg_one_d};
    end else if (aph_go && !HWRITE && aph_hit[1]) begin
      rdata_d = {24'h000000, cfg_two_d};
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      dph_wr_q <= 1'b0;
      dph_hit_q <= 2'h0;
      cfg_one_q <= iocfg_pkg::IO_CONFIG_ONE_RST;
      cfg_two_q <= iocfg_pkg::IO_CONFIG_TWO_RST;
      rdata_q <= 32'h00000000;
    end else begin
      dph_wr_q <= dph_wr_d;
      dph_hit_q <= dph_hit_d;
      cfg_one_q <= cfg_one_d;
      cfg_two_q <= cfg_two_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-frequency clock divider, free running from the reference clock

  logic [9:0] lf_cnt_q;
  logic [9:0] lf_cnt_d;
  logic lf_clk_q;
  logic lf_clk_d;

  // Half period is truncated, so the clock runs a hair above 32 kHz
  always_comb begin
    lf_cnt_d = lf_cnt_q + 10'h001;
    lf_clk_d = lf_clk_q;
    if (lf_cnt_q == LF_LAST) begin
      lf_cnt_d = 10'h000;
      lf_clk_d = ~lf_clk_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      lf_cnt_q <= 10'h000;
      lf_clk_q <= 1'b0;
    end else begin
      lf_cnt_q <= lf_cnt_d;
      lf_clk_q <= lf_clk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter turn-on ramp

  iocfg_pkg::iocfg_ramp_e ramp_st_q;
  iocfg_pkg::iocfg_ramp_e ramp_st_d;
  logic [9:0] step_cnt_q;
  logic [9:0] step_cnt_d;
  logic [3:0] tx_lvl_q;
  logic [3:0] tx_lvl_d;
  logic slow_ramp;

  assign slow_ramp = cfg_two_q[iocfg_pkg::SLOW_RAMP_BIT];

  // stepped rise; ten steps of STEP_CYC span at least 10 us
  always_comb begin
    ramp_st_d = ramp_st_q;
    step_cnt_d = step_cnt_q;
    tx_lvl_d = tx_lvl_q;
    case (ramp_st_q)
      iocfg_pkg::RAMP_IDLE: begin
        tx_lvl_d = 4'h0;
        step_cnt_d = 10'h000;
        if (TX_ON && slow_ramp) begin
          ramp_st_d = iocfg_pkg::RAMP_RISE;
        end else if (TX_ON) begin
          ramp_st_d = iocfg_pkg::RAMP_ON;
          tx_lvl_d = iocfg_pkg::TX_LEVEL_FULL;
        end
      end
      iocfg_pkg::RAMP_RISE: begin
        if (!TX_ON) begin
          ramp_st_d = iocfg_pkg::RAMP_IDLE;
          tx_lvl_d = 4'h0;
        end else if (step_cnt_q == STEP_LAST) begin
          step_cnt_d = 10'h000;
          tx_lvl_d = tx_lvl_q + 4'h1;
          if (tx_lvl_q == iocfg_pkg::TX_LEVEL_FULL - 4'h1) begin
            ramp_st_d = iocfg_pkg::RAMP_ON;
          end
        end else begin
          step_cnt_d = step_cnt_q + 10'h001;
        end
      end
      iocfg_pkg::RAMP_ON: begin
        if (!TX_ON) begin
          ramp_st_d = iocfg_pkg::RAMP_IDLE;
          tx_lvl_d = 4'h0;
        end
      end
      default: begin
        ramp_st_d = iocfg_pkg::RAMP_IDLE;
        tx_lvl_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ramp_st_q <= iocfg_pkg::RAMP_IDLE;
      step_cnt_q <= 10'h000;
      tx_lvl_q <= 4'h0;
    end else begin
      ramp_st_q <= ramp_st_d;
      step_cnt_q <= step_cnt_d;
      tx_lvl_q <= tx_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded control outputs, all registered

  logic [1:0] clk_sel;
  logic single_d;
  logic drv_one_d;
  logic drv_two_d;
  logic in_two_d;
  logic [6:0] rx_wl_d;
  logic [6:0] tx_wl_d;
  logic host_clk_d;
  logic pd_en_d;
  logic single_q;
  logic drv_one_q;
  logic drv_two_q;
  logic in_two_q;
  logic [6:0] rx_wl_q;
  logic [6:0] tx_wl_q;
  logic host_clk_q;
  logic pd_en_q;

  assign clk_sel = {cfg_one_q[iocfg_pkg::HOST_CLK_SEL_HI_BIT],
                    cfg_one_q[iocfg_pkg::HOST_CLK_SEL_LO_BIT]};

  always_comb begin
    single_d = cfg_one_q[iocfg_pkg::SINGLE_DRIVE_BIT];
    drv_one_d = !single_d || !cfg_one_q[iocfg_pkg::SECOND_DRIVER_SELECT_BIT];
    drv_two_d = !single_d || cfg_one_q[iocfg_pkg::SECOND_DRIVER_SELECT_BIT];
    in_two_d = single_d && cfg_one_q[iocfg_pkg::SECOND_DRIVER_SELECT_BIT];
    rx_wl_d = cfg_one_q[iocfg_pkg::RX_WATER_LEVEL_SEL_BIT] ?
              iocfg_pkg::RX_LEVEL_HIGH : iocfg_pkg::RX_LEVEL_LOW;
    tx_wl_d = cfg_one_q[iocfg_pkg::TX_WATER_LEVEL_SEL_BIT] ?
              iocfg_pkg::TX_LEVEL_HIGH : iocfg_pkg::TX_LEVEL_LOW;
    // crystal-derived clock while the oscillator runs
    // otherwise the low-frequency clock unless suppressed
    if (clk_sel == iocfg_pkg::HOST_CLK_OFF) begin
      host_clk_d = 1'b0;
    end else if (osc_run_s) begin
      host_clk_d = xtal_clk_s;
    end else begin
      host_clk_d = lf_clk_q && !cfg_one_q[iocfg_pkg::LOW_FREQ_CLK_SUPPRESS_BIT];
    end
    pd_en_d = (cfg_two_q[iocfg_pkg::DATAOUT_PULLDOWN_SELECTED_BIT] && !ss_n_s && !MISO_OE) ||
              (cfg_two_q[iocfg_pkg::DATAOUT_PULLDOWN_IDLE_BIT] && ss_n_s);
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      single_q <= 1'b0;
      drv_one_q <= 1'b1;
      drv_two_q <= 1'b1;
      in_two_q <= 1'b0;
      rx_wl_q <= iocfg_pkg::RX_LEVEL_LOW;
      tx_wl_q <= iocfg_pkg::TX_LEVEL_LOW;
      host_clk_q <= 1'b0;
      pd_en_q <= 1'b0;
    end else begin
      single_q <= single_d;
      drv_one_q <= drv_one_d;
      drv_two_q <= drv_two_d;
      in_two_q <= in_two_d;
      rx_wl_q <= rx_wl_d;
      tx_wl_q <= tx_wl_d;
      host_clk_q <= host_clk_d;
      pd_en_q <= pd_en_d;
    end
  end

  // Zero wait states and always OKAY; register bits drive the static outputs
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign SINGLE_DRIVE = single_q;
  assign ANT_DRV_ONE_EN = drv_one_q;
  assign ANT_DRV_TWO_EN = drv_two_q;
  assign ANT_IN_TWO_SEL = in_two_q;
  assign RX_WATER_LEVEL = rx_wl_q;
  assign TX_WATER_LEVEL = tx_wl_q;
  assign XTAL_27M_SEL = cfg_one_q[iocfg_pkg::XTAL_SEL_BIT];
  assign HOST_CLK_DIV = clk_sel;
  assign HOST_CLK = host_clk_q;
  assign MISO_PD_EN = pd_en_q;
  assign MISO_DRIVE_HI = cfg_two_q[iocfg_pkg::DATAOUT_DRIVE_HIGH_BIT];
  assign LOW_SUPPLY_MODE = cfg_two_q[iocfg_pkg::LOW_SUPPLY_MODE_BIT];
  assign DIG_REG_OFF = cfg_two_q[iocfg_pkg::DIGITAL_REG_OFF_BIT];
  assign TX_RAMP_SLOW = slow_ramp;
  assign TX_LEVEL = tx_lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence write_one_s;
    aph_go && HWRITE && aph_hit[0] ##1 1'b1;
  endsequence

  sequence slow_start_s;
    ramp_st_q == iocfg_pkg::RAMP_IDLE && TX_ON && slow_ramp;
  endsequence

  single_drive_a: assert property (
    ##1 SINGLE_DRIVE == $past(cfg_one_q[iocfg_pkg::SINGLE_DRIVE_BIT]))
    else $error("single drive output does not follow its bit");

  driver_pair_a: assert property (
    SINGLE_DRIVE |-> (ANT_DRV_ONE_EN != ANT_DRV_TWO_EN) && (ANT_IN_TWO_SEL == ANT_DRV_TWO_EN))
    else $error("single drive enables the wrong driver pair");

  rx_level_a: assert property (
    ##1 RX_WATER_LEVEL == ($past(cfg_one_q[5]) ? 7'h50 : 7'h40))
    else $error("receive water level wrong");

  tx_level_a: assert property (
    ##1 TX_WATER_LEVEL == ($past(cfg_one_q[4]) ? 7'h10 : 7'h20))
    else $error("transmit water level wrong");

  host_clk_off_a: assert property (
    (clk_sel == 2'h3) [*2] |-> !HOST_CLK)
    else $error("host clock not held low when disabled");

  lf_suppress_a: assert property (
    (cfg_one_q[0] && !osc_run_s) [*2] |-> !HOST_CLK)
    else $error("low-frequency clock not suppressed");

  pulldown_idle_a: assert property (
    cfg_two_q[3] && ss_n_s |=> MISO_PD_EN)
    else $error("idle pull-down missing");

  write_store_a: assert property (
    write_one_s |=> (cfg_one_q == $past(HWDATA[7:0])) && ((cfg_two_q & 8'h22) == 8'h00))
    else $error("write to first register not stored");

  slow_ramp_a: assert property (
    slow_start_s |=> (TX_LEVEL < 4'hF) [*8])
    else $error("slow ramp reached full level too early");

  readback_a: assert property (
    aph_go && !HWRITE && aph_hit[1] |=> HRDATA == {24'h000000, cfg_two_q})
    else $error("read of second register returns wrong data");

endmodule

/* include/iocfg_pkg.sv */
// Constants shared by the IO configuration register bank
package iocfg_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [29:0] IO_CONFIG_ONE_IDX = 30'h00000000;
  localparam logic [29:0] IO_CONFIG_TWO_IDX = 30'h00000001;

  // Values after power-up
  localparam logic [7:0] IO_CONFIG_ONE_RST = 8'h08;
  localparam logic [7:0] IO_CONFIG_TWO_RST = 8'h00;

  // Bits that hold state; the rest ignore writes and read as zero
  localparam logic [7:0] IO_CONFIG_ONE_MASK = 8'hFF;
  localparam logic [7:0] IO_CONFIG_TWO_MASK = 8'hDD;

  // Field positions of the first register
  localparam int SINGLE_DRIVE_BIT = 7;
  localparam int SECOND_DRIVER_SELECT_BIT = 6;
  localparam int RX_WATER_LEVEL_SEL_BIT = 5;
  localparam int TX_WATER_LEVEL_SEL_BIT = 4;
  localparam int XTAL_SEL_BIT = 3;
  localparam int HOST_CLK_SEL_HI_BIT = 2;
  localparam int HOST_CLK_SEL_LO_BIT = 1;
  localparam int LOW_FREQ_CLK_SUPPRESS_BIT = 0;

  // Field positions of the second register
  localparam int LOW_SUPPLY_MODE_BIT = 7;
  localparam int DIGITAL_REG_OFF_BIT = 6;
  localparam int DATAOUT_PULLDOWN_SELECTED_BIT = 4;
  localparam int DATAOUT_PULLDOWN_IDLE_BIT = 3;
  localparam int DATAOUT_DRIVE_HIGH_BIT = 2;
  localparam int SLOW_RAMP_BIT = 0;

  // Water levels in bytes
  localparam logic [6:0] RX_LEVEL_LOW = 7'h40;
  localparam logic [6:0] RX_LEVEL_HIGH = 7'h50;
  localparam logic [6:0] TX_LEVEL_LOW = 7'h20;
  localparam logic [6:0] TX_LEVEL_HIGH = 7'h10;

  // Host clock select codes
  localparam logic [1:0] HOST_CLK_3M39 = 2'h0;
  localparam logic [1:0] HOST_CLK_6M78 = 2'h1;
  localparam logic [1:0] HOST_CLK_13M56 = 2'h2;
  localparam logic [1:0] HOST_CLK_OFF = 2'h3;

  // Timing on the 50 MHz reference clock
  localparam int REF_CLK_PERIOD_NS = 20;
  localparam int LF_CLK_HZ = 32000;
  localparam int LF_HALF_CYC = 1000000000 / (2 * LF_CLK_HZ * REF_CLK_PERIOD_NS);
  localparam int SLOW_RAMP_NS = 10000;
  localparam int SLOW_RAMP_CYC = (SLOW_RAMP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int RAMP_SPAN = 10;
  localparam int RAMP_STEP_CYC = (SLOW_RAMP_CYC + RAMP_SPAN - 1) / RAMP_SPAN;
  localparam logic [3:0] TX_LEVEL_FULL = 4'hF;

  // Transmitter ramp states
  typedef enum logic [2:0] {
    RAMP_IDLE = 3'h1,
    RAMP_RISE = 3'h2,
    RAMP_ON = 3'h4
  } iocfg_ramp_e;

endpackage

/* design/iocfg_sync.sv */
// Multi-stage level synchroniser for pins entering the reference clock domain
`timescale 1ns/1ps
module iocfg_sync #(
  parameter int STAGES = 2,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  // Fewer than two stages would expose a metastable flop to logic
  generate
    if (STAGES < 2) begin : g_bad_stages
      $error("iocfg_sync needs at least two stages");
    end
  endgenerate

  // Shift the pin through the chain; only the last stage leaves
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], async_in};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= {STAGES{RST_VAL}};
    end else begin
      chain_q <= chain_d;
    end
  end

  assign sync_out = chain_q[STAGES-1];

endmodule

/* bench/iocfg_xtal_model.sv */
// Crystal clock block model that drives the oscillator and divided clock pins
`timescale 1ns/1ps
module iocfg_xtal_model (
  input wire logic osc_en,
  input wire logic [1:0] div_sel,
  output logic osc_running,
  output logic xtal_div_clk
);
  ////////////////////////////////////////////////////////////////////////////////
  // Half periods are arbitrary, differ per code, and are unrelated to REF_CLK,
  // so that the block sees a truly asynchronous divided clock
  initial begin
    osc_running = 1'b0;
    xtal_div_clk = 1'b0;
    forever begin
      if (osc_en === 1'b1) begin
        osc_running = 1'b1;
        #(37 * (int'(div_sel) + 1));
        xtal_div_clk = ~xtal_div_clk;
      end else begin
        // A stopped crystal gives no edges at all, not a frozen high level
        osc_running = 1'b0;
        xtal_div_clk = 1'b0;
        @(osc_en);
      end
    end
  end
endmodule

/* bench/iocfg_regs_tb_top.sv */
// Self-checking bench for the IO configuration register bank
`timescale 1ns/1ps
module iocfg_regs_tb_top;
  // Short counts keep the clock and ramp scenarios brief
  localparam int LF_H = 4;
  localparam int STEP = 2;
  localparam logic [31:0] A1 = {iocfg_pkg::IO_CONFIG_ONE_IDX, 2'h0};
  localparam logic [31:0] A2 = {iocfg_pkg::IO_CONFIG_TWO_IDX, 2'h0};
  localparam logic [7:0] RST1 = iocfg_pkg::IO_CONFIG_ONE_RST;
  localparam logic [7:0] RST2 = iocfg_pkg::IO_CONFIG_TWO_RST;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic SS_N = 1'b1;
  logic MISO_OE = 1'b0;
  logic TX_ON = 1'b0;
  logic osc_en = 1'b0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic OSC_RUNNING;
  logic XTAL_DIV_CLK;
  logic SINGLE_DRIVE;
  logic ANT_DRV_ONE_EN;
  logic ANT_DRV_TWO_EN;
  logic ANT_IN_TWO_SEL;
  logic [6:0] RX_WATER_LEVEL;
  logic [6:0] TX_WATER_LEVEL;
  logic XTAL_27M_SEL;
  logic [1:0] HOST_CLK_DIV;
  logic HOST_CLK;
  logic MISO_PD_EN;
  logic MISO_DRIVE_HI;
  logic LOW_SUPPLY_MODE;
  logic DIG_REG_OFF;
  logic TX_RAMP_SLOW;
  logic [3:0] TX_LEVEL;
  logic [31:0] dec_got;
  logic [31:0] exp_q[$];
  logic rd_dph = 1'b0;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h341C841B;
  int tg;
  int hi;
  logic [31:0] d1;
  logic [31:0] d2;

  // All static decoded configuration outputs in one word; HOST_CLK, MISO_PD_EN and TX_LEVEL are checked apart
  assign dec_got = {7'h0, SINGLE_DRIVE, ANT_DRV_ONE_EN, ANT_DRV_TWO_EN, ANT_IN_TWO_SEL,
    RX_WATER_LEVEL, TX_WATER_LEVEL, XTAL_27M_SEL, HOST_CLK_DIV, MISO_DRIVE_HI,
    LOW_SUPPLY_MODE, DIG_REG_OFF, TX_RAMP_SLOW};

  // The single slave's ready is the bus ready
  iocfg_regs #(.LF_HALF(LF_H), .STEP_CYC(STEP)) iocfg_regs_i (.REF_CLK, .NRST, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .OSC_RUNNING, .XTAL_DIV_CLK, .SS_N, .MISO_OE, .TX_ON, .SINGLE_DRIVE, .ANT_DRV_ONE_EN,
    .ANT_DRV_TWO_EN, .ANT_IN_TWO_SEL, .RX_WATER_LEVEL, .TX_WATER_LEVEL, .XTAL_27M_SEL,
    .HOST_CLK_DIV, .HOST_CLK, .MISO_PD_EN, .MISO_DRIVE_HI, .LOW_SUPPLY_MODE, .DIG_REG_OFF,
    .TX_RAMP_SLOW, .TX_LEVEL);

  iocfg_xtal_model iocfg_xtal_model_i (.osc_en(osc_en), .div_sel(HOST_CLK_DIV),
    .osc_running(OSC_RUNNING), .xtal_div_clk(XTAL_DIV_CLK));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected decode, worked out from the field meanings
  function automatic logic [31:0] exp_dec(input logic [7:0] a, input logic [7:0] b);
    exp_dec = {7'h0, a[7], !(a[7] & a[6]), !(a[7] & !a[6]), a[7] & a[6],
      a[5] ? iocfg_pkg::RX_LEVEL_HIGH : iocfg_pkg::RX_LEVEL_LOW,
      a[4] ? iocfg_pkg::TX_LEVEL_HIGH : iocfg_pkg::TX_LEVEL_LOW, a[3], a[2:1], b[2], b[7],
      b[6], b[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Single bus transfer; for a read, d is the expected data
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
    input logic [2:0] sz);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    HSIZE <= sz;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wr ? d : 32'h0;
    rd_dph <= !wr;
    if (!wr) begin
      exp_q.push_back(d);
    end
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd_dph <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask

  task automatic reset_dut;
    @(posedge REF_CLK);
    NRST <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    NRST <= 1'b1;
  endtask

  // Counts edges and high samples of the host clock output
  task automatic watch_clk(input int n, output int t, output int h);
    logic p;
    t = 0;
    h = 0;
    p = HOST_CLK;
    repeat (n) begin
      @(negedge REF_CLK);
      if (HOST_CLK !== p) t++;
      if (HOST_CLK === 1'b1) h++;
      p = HOST_CLK;
    end
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge REF_CLK) begin
    if (rd_dph && HREADYOUT === 1'b1) begin
      chk("read data", exp_q.pop_front(), HRDATA);
      chk("response", 32'h0, {31'h0, HRESP});
    end
  end

  // Hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      $display("MISMATCH timeout expected 0 seen %0d", cyc);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_dut();
    bus(1'b0, A1, {24'h0, RST1}, 3'h2);
    bus(1'b0, A2, {24'h0, RST2}, 3'h2);
    settle(1);
    chk("reset decode", exp_dec(RST1, RST2), dec_got);
    // Random values, every drive mode forced in turn
    for (int i = 0; i < 12; i++) begin
      d1 = $random(seed);
      d2 = $random(seed);
      d1[7:6] = i[1:0];
      bus(1'b1, A1, d1, 3'h2);
      bus(1'b1, A2, d2, 3'h2);
      bus(1'b0, A1, {24'h0, d1[7:0]}, 3'h2);
      bus(1'b0, A2, {24'h0, d2[7:0] & iocfg_pkg::IO_CONFIG_TWO_MASK}, 3'h2);
      settle(1);
      chk("decode", exp_dec(d1[7:0], d2[7:0]), dec_got);
    end
    // Unmapped address and byte size are ignored
    bus(1'b1, 32'h8, 32'hFF, 3'h2);
    bus(1'b0, 32'h8, 32'h0, 3'h2);
    bus(1'b1, A1, 32'h0, 3'h0);
    bus(1'b0, A1, {24'h0, d1[7:0]}, 3'h2);
    // Every pull-down setting against select and drive state
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, A2, {27'h0, i[3:2], 3'h0}, 3'h2);
      @(posedge REF_CLK);
      SS_N <= i[1];
      MISO_OE <= i[0];
      settle(4);
      chk("pulldown", (i[3] & !i[1] & !i[0]) | (i[2] & i[1]), MISO_PD_EN);
    end
    // Host clock codes with the crystal running
    @(posedge REF_CLK);
    osc_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, A1, {24'h0, 5'h01, c[1:0], 1'b0}, 3'h2);
      settle(8);
      watch_clk(100, tg, hi);
      chk("host clock active", c != 3, tg != 0);
      chk("host clock div", c, HOST_CLK_DIV);
      if (c == 3) chk("host clock high", 0, hi);
    end
    // Low-frequency clock with the crystal stopped
    @(posedge REF_CLK);
    osc_en <= 1'b0;
    bus(1'b1, A1, 32'h08, 3'h2);
    settle(8);
    watch_clk(100, tg, hi);
    chk("lf clock", 1, tg >= 100 / LF_H - 2 && tg <= 100 / LF_H + 2);
    bus(1'b1, A1, 32'h09, 3'h2);
    settle(8);
    watch_clk(100, tg, hi);
    chk("lf suppressed", 0, tg + hi);
    bus(1'b1, A1, 32'h0E, 3'h2);
    settle(8);
    watch_clk(100, tg, hi);
    chk("clock disabled", 0, tg + hi);
    // Fast turn-on, then the slow ramp
    bus(1'b1, A2, 32'h0, 3'h2);
    @(posedge REF_CLK);
    TX_ON <= 1'b1;
    settle(2);
    chk("fast turn-on", iocfg_pkg::TX_LEVEL_FULL, TX_LEVEL);
    @(posedge REF_CLK);
    TX_ON <= 1'b0;
    settle(2);
    chk("tx off", 0, TX_LEVEL);
    bus(1'b1, A2, 32'h1, 3'h2);
    @(posedge REF_CLK);
    TX_ON <= 1'b1;
    settle(STEP * 4);
    chk("ramp partial", 1, TX_LEVEL > 0 && TX_LEVEL < iocfg_pkg::TX_LEVEL_FULL);
    settle(STEP * 16);
    chk("ramp full", iocfg_pkg::TX_LEVEL_FULL, TX_LEVEL);
    @(posedge REF_CLK);
    TX_ON <= 1'b0;
    // Power-up reset in mid-run brings the defaults back
    reset_dut();
    bus(1'b0, A1, {24'h0, RST1}, 3'h2);
    bus(1'b0, A2, {24'h0, RST2}, 3'h2);
    settle(2);
    end_sim();
  end
endmodule
